// File: logic/pmc_cfg.svh
// Constants for the power mode controller: offsets, fields, reset values, timing
// Function
// - Mode field value 0x2 selects normal regulator operation.
// - Mode field value 0x3 selects economy, low-drive power-saving operation.
// - Mode field value 0x0 selects automatic normal/economy switching by hardware.
// - Mode field value 0x5 selects super economy, core supply from charge pump.
// - Mode writes take effect only while protect key holds 0x0096.
// - Auto normal: all fast sources stopped, wait 1 ms, enter economy, set flag.
// - Auto economy: any fast source started returns to normal at once.
// - Auto sleep with all clocks stopping: economy at sleep entry, flag untouched.
// - Auto sleep with only low-speed oscillator: economy 1 ms later, set flag.
// - Sleep entry with a fast source active keeps normal operation.
// - Wake in auto: economy if only low-speed oscillator runs, else normal.
// - Charge pump clock is low-speed oscillator clock divided by programmed ratio.
// - Leaving super economy for auto or economy sets flag after 10 ms.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_OFS_PROTECT 8'h00
`define PMC_OFS_CONTROL 8'h04
`define PMC_OFS_TIMING 8'h08
`define PMC_OFS_FLAG 8'h0C
`define PMC_OFS_IRQ_EN 8'h10
`define PMC_OFS_STATUS 8'h14

`define PMC_PROTECT_KEY 16'h0096
`define PMC_PROTECT_RST 16'h0000
`define PMC_MODE_RST 3'h0
`define PMC_PUMP_DIV_RST 2'h0

`define PMC_MODE_LSB 0
`define PMC_PUMP_DIV_LSB 0
`define PMC_FLAG_BIT 0
`define PMC_IRQ_EN_BIT 0

`define PMC_CLK_PERIOD_NS 25
`define PMC_T_AUTO_US 1000
`define PMC_T_RECOVER_US 10000
`define PMC_AUTO_CYC ((`PMC_T_AUTO_US * 1000 + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_RECOVER_CYC ((`PMC_T_RECOVER_US * 1000 + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`endif

// File: logic/pmc_pkg.sv
// Types shared by the power mode controller
package pmc_pkg;

  typedef enum logic [2:0] {
    PMC_MODE_AUTO = 3'h0,
    PMC_MODE_NORMAL = 3'h2,
    PMC_MODE_ECONOMY = 3'h3,
    PMC_MODE_SUPER = 3'h5
  } pmc_mode_t;

  typedef enum logic [3:0] {
    PMC_ST_NORMAL = 4'b0001,
    PMC_ST_ECONOMY = 4'b0010,
    PMC_ST_SUPER = 4'b0100,
    PMC_ST_RECOVER = 4'b1000
  } pmc_state_t;

endpackage

// File: logic/pmc_pump_clk_div.sv
// Charge pump clock divider fed by the low-speed oscillator clock pin
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_pump_clk_div #(
  parameter int DIV_W = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic lsosc_clk,
  input wire logic [DIV_W-1:0] div_sel,
  input wire logic enable,
  output logic pump_clk
);
  import pmc_pkg::*;

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic [7:0] edge_cnt;
  logic [7:0] edge_last;

  assign edge_last = 8'((1 << div_sel) - 1);

  // Two-stage synchroniser, third stage only for edge detect
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= lsosc_clk;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Toggle every 2^div_sel rising edges of the low-speed clock
  always_ff @(posedge clk_sys) begin
    if (rst || !enable) begin
      edge_cnt <= 8'h00;
      pump_clk <= 1'b0;
    end else if (sync_b && !sync_c) begin
      if (edge_cnt >= edge_last) begin
        edge_cnt <= 8'h00;
        pump_clk <= !pump_clk;
      end else begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end

endmodule

// File: logic/pmc_power_mode_controller.sv
// Power mode controller: mode registers, automatic normal/economy switching, timers
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_power_mode_controller #(
  parameter int AUTO_CYC = `PMC_AUTO_CYC,
  parameter int RECOVER_CYC = `PMC_RECOVER_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic internal_fast_osc_on,
  input wire logic external_fast_osc_on,
  input wire logic external_clock_input_on,
  input wire logic lowspeed_crystal_osc_on,
  input wire logic lowspeed_osc_sleep_stop,
  input wire logic fast_osc_sleep_stop,
  input wire logic cpu_sleep_enter,
  input wire logic cpu_wake,
  input wire logic lowspeed_osc_clk,
  output pmc_pkg::pmc_state_t regulator_state,
  output logic regulator_economy,
  output logic charge_pump_en,
  output logic pump_clk,
  output logic irq
);
  import pmc_pkg::*;

  logic [15:0] protect_key;
  pmc_mode_t regulator_mode_select;
  logic [1:0] pump_clock_divider;
  logic transition_complete_flag;
  logic irq_enable;
  logic cpu_asleep;
  pmc_state_t state;
  logic [18:0] tmr;

  logic unlocked;
  logic mode_wr;
  logic mode_legal;
  logic fast_active;
  logic only_lowspeed;
  logic auto_mode;
  logic sleep_all_stop;
  logic auto_wait;
  logic tmr_run;
  logic auto_done;
  logic rec_done;
  logic flag_set;
  logic flag_clr;

  assign unlocked = (protect_key == `PMC_PROTECT_KEY);
  assign mode_legal = (wdata[2:0] == PMC_MODE_AUTO) || (wdata[2:0] == PMC_MODE_NORMAL) ||
                      (wdata[2:0] == PMC_MODE_ECONOMY) || (wdata[2:0] == PMC_MODE_SUPER);
  assign mode_wr = wr && (addr == `PMC_OFS_CONTROL) && unlocked && mode_legal;
  assign fast_active = internal_fast_osc_on || external_fast_osc_on || external_clock_input_on;
  assign only_lowspeed = !fast_active && lowspeed_crystal_osc_on;
  assign auto_mode = (regulator_mode_select == PMC_MODE_AUTO);
  assign sleep_all_stop = lowspeed_osc_sleep_stop && fast_osc_sleep_stop;
  assign auto_wait = (state == PMC_ST_NORMAL) && auto_mode && !fast_active && !cpu_sleep_enter;
  assign tmr_run = auto_wait || (state == PMC_ST_RECOVER);
  assign auto_done = auto_wait && (tmr == 19'(AUTO_CYC - 1));
  assign rec_done = (state == PMC_ST_RECOVER) && (tmr == 19'(RECOVER_CYC - 1));
  assign flag_set = auto_done || (rec_done && (regulator_mode_select != PMC_MODE_NORMAL));
  assign flag_clr = wr && (addr == `PMC_OFS_FLAG) && wdata[`PMC_FLAG_BIT];

  // Protection key
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      protect_key <= `PMC_PROTECT_RST;
    end else if (wr && addr == `PMC_OFS_PROTECT) begin
      protect_key <= wdata;
    end
  end

  // Mode select, protected
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regulator_mode_select <= pmc_mode_t'(`PMC_MODE_RST);
    end else if (mode_wr) begin
      regulator_mode_select <= pmc_mode_t'(wdata[`PMC_MODE_LSB +: 3]);
    end
  end

  // Pump clock division and interrupt enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pump_clock_divider <= `PMC_PUMP_DIV_RST;
      irq_enable <= 1'b0;
    end else if (wr) begin
      if (addr == `PMC_OFS_TIMING) begin
        pump_clock_divider <= wdata[`PMC_PUMP_DIV_LSB +: 2];
      end
      if (addr == `PMC_OFS_IRQ_EN) begin
        irq_enable <= wdata[`PMC_IRQ_EN_BIT];
      end
    end
  end

  // Sticky flag, set beats write-one clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      transition_complete_flag <= 1'b0;
    end else if (flag_set) begin
      transition_complete_flag <= 1'b1;
    end else if (flag_clr) begin
      transition_complete_flag <= 1'b0;
    end
  end

  // CPU run/sleep tracking
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_asleep <= 1'b0;
    end else if (cpu_wake) begin
      cpu_asleep <= 1'b0;
    end else if (cpu_sleep_enter) begin
      cpu_asleep <= 1'b1;
    end
  end

  // Delay timer, restarted at sleep entry and whenever idle
  always_ff @(posedge clk_sys) begin
    if (rst || !tmr_run || auto_done || rec_done) begin
      tmr <= 19'h00000;
    end else begin
      tmr <= tmr + 19'h00001;
    end
  end

  // Regulator state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= PMC_ST_NORMAL;
    end else begin
      unique case (state)
        PMC_ST_NORMAL: begin
          if (regulator_mode_select == PMC_MODE_ECONOMY) begin
            state <= PMC_ST_ECONOMY;
          end else if (regulator_mode_select == PMC_MODE_SUPER) begin
            state <= PMC_ST_SUPER;
          end else if (auto_mode) begin
            if (cpu_sleep_enter && sleep_all_stop && !fast_active) begin
              state <= PMC_ST_ECONOMY;
            end else if (auto_done) begin
              state <= PMC_ST_ECONOMY;
            end
          end
        end
        PMC_ST_ECONOMY: begin
          if (regulator_mode_select == PMC_MODE_NORMAL) begin
            state <= PMC_ST_NORMAL;
          end else if (regulator_mode_select == PMC_MODE_SUPER) begin
            state <= PMC_ST_SUPER;
          end else if (auto_mode) begin
            if (cpu_wake) begin
              state <= only_lowspeed ? PMC_ST_ECONOMY : PMC_ST_NORMAL;
            end else if (fast_active) begin
              state <= PMC_ST_NORMAL;
            end
          end
        end
        PMC_ST_SUPER: begin
          if (regulator_mode_select != PMC_MODE_SUPER) begin
            state <= PMC_ST_RECOVER;
          end
        end
        PMC_ST_RECOVER: begin
          if (regulator_mode_select == PMC_MODE_SUPER) begin
            state <= PMC_ST_SUPER;
          end else if (rec_done) begin
            if (regulator_mode_select == PMC_MODE_ECONOMY || (auto_mode && only_lowspeed)) begin
              state <= PMC_ST_ECONOMY;
            end else begin
              state <= PMC_ST_NORMAL;
            end
          end
        end
        default: begin
          state <= PMC_ST_NORMAL;
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regulator_state <= PMC_ST_NORMAL;
      regulator_economy <= 1'b0;
      charge_pump_en <= 1'b0;
      irq <= 1'b0;
    end else begin
      regulator_state <= state;
      regulator_economy <= (state == PMC_ST_ECONOMY);
      charge_pump_en <= (state == PMC_ST_SUPER);
      irq <= transition_complete_flag && irq_enable;
    end
  end

  // Register read, data in the following cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        `PMC_OFS_PROTECT: rdata <= {15'h0000, unlocked};
        `PMC_OFS_CONTROL: rdata <= {13'h0000, regulator_mode_select};
        `PMC_OFS_TIMING: rdata <= {14'h0000, pump_clock_divider};
        `PMC_OFS_FLAG: rdata <= {15'h0000, transition_complete_flag};
        `PMC_OFS_IRQ_EN: rdata <= {15'h0000, irq_enable};
        `PMC_OFS_STATUS: rdata <= {11'h000, cpu_asleep, state};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Pump clock from the low-speed oscillator
  pmc_pump_clk_div #(
    .DIV_W(2)
  ) u_pump_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .lsosc_clk(lowspeed_osc_clk),
    .div_sel(pump_clock_divider),
    .enable(state == PMC_ST_SUPER),
    .pump_clk(pump_clk)
  );

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_key_locks_mode: assert property (
    (wr && addr == `PMC_OFS_CONTROL && !unlocked) |=> $stable(regulator_mode_select))
    else $error("mode changed while protected");
  a_normal_select: assert property (
    (mode_wr && wdata[2:0] == 3'h2 && state == PMC_ST_ECONOMY) |=> ##1 (state == PMC_ST_NORMAL))
    else $error("normal mode not entered");
  a_economy_select: assert property (
    (mode_wr && wdata[2:0] == 3'h3 && state == PMC_ST_NORMAL) |=> ##1 (state == PMC_ST_ECONOMY))
    else $error("economy mode not entered");
  a_super_pump_on: assert property (
    (state == PMC_ST_SUPER) |=> charge_pump_en)
    else $error("charge pump not enabled in super economy");
  a_auto_fast_wake: assert property (
    (state == PMC_ST_ECONOMY && auto_mode && fast_active && !cpu_wake) |=> (state == PMC_ST_NORMAL))
    else $error("fast source did not restore normal");
  a_sleep_all_stop: assert property (
    (state == PMC_ST_NORMAL && auto_mode && cpu_sleep_enter && sleep_all_stop && !fast_active)
    |=> (state == PMC_ST_ECONOMY) && $stable(transition_complete_flag))
    else $error("all-stop sleep entry wrong");
  a_sleep_fast_stay: assert property (
    (state == PMC_ST_NORMAL && auto_mode && cpu_sleep_enter && fast_active) |=> (state == PMC_ST_NORMAL))
    else $error("economy entered with fast source active");
  a_wake_select: assert property (
    (state == PMC_ST_ECONOMY && auto_mode && cpu_wake)
    |=> (state == ($past(only_lowspeed) ? PMC_ST_ECONOMY : PMC_ST_NORMAL)))
    else $error("wrong state after wake");
  a_auto_delay: assert property (
    (state == PMC_ST_NORMAL && $past(state) == PMC_ST_NORMAL ##1 state == PMC_ST_ECONOMY && auto_mode
     && $past(auto_mode) && !$past(cpu_sleep_enter)) |-> transition_complete_flag)
    else $error("timed economy entry without flag");
  a_recover_delay: assert property (
    (state == PMC_ST_RECOVER && tmr != 19'(RECOVER_CYC - 1) && regulator_mode_select != PMC_MODE_SUPER)
    |=> (state == PMC_ST_RECOVER))
    else $error("left recovery before 10 ms");
  a_flag_sticky: assert property (
    (transition_complete_flag && !flag_clr) |=> transition_complete_flag)
    else $error("flag dropped without clear");
  a_irq_follows: assert property (
    (transition_complete_flag && irq_enable) |=> irq)
    else $error("interrupt not raised");

  c_auto_economy: cover property (auto_done ##1 state == PMC_ST_ECONOMY);
  c_super_exit: cover property (rec_done ##1 transition_complete_flag);
  c_sleep_econ: cover property (cpu_sleep_enter && sleep_all_stop ##1 state == PMC_ST_ECONOMY);
  c_wake_normal: cover property (cpu_wake && state == PMC_ST_ECONOMY ##1 state == PMC_ST_NORMAL);

endmodule

// File: testbench/pmc_clk_cpu_model.sv
// Behavioural clock generator and CPU sleep control facing the power mode controller
`timescale 1ns/1ps
module pmc_clk_cpu_model #(
  parameter real LS_HALF_NS = 170.0
) (
  output logic [2:0] fast_on,
  output logic ls_on,
  output logic ls_stop,
  output logic fast_stop,
  output logic sleep_enter,
  output logic wake,
  output logic ls_clk,
  input wire logic clk_sys
);
  // Boot with the internal fast oscillator running, low-speed oscillator stable
  initial begin
    fast_on = 3'h1;
    ls_on = 1'b1;
    {ls_stop, fast_stop} = 2'b11;
    {sleep_enter, wake, ls_clk} = 3'b000;
  end

  // Low-speed oscillator runs free while enabled
  always #(LS_HALF_NS) ls_clk = ls_on ? ~ls_clk : 1'b0;

  task automatic set_fast(input logic [2:0] v);
    @(posedge clk_sys);
    fast_on <= v;
  endtask

  // Sleep configuration of the oscillators
  task automatic cfg_sleep(input logic ls_s, input logic fast_s);
    @(posedge clk_sys);
    ls_stop <= ls_s;
    fast_stop <= fast_s;
  endtask

  // Sleep entry stops the low-speed oscillator only when so configured
  task automatic sleep_cpu();
    @(posedge clk_sys);
    sleep_enter <= 1'b1;
    ls_on <= ~ls_stop;
    @(posedge clk_sys);
    sleep_enter <= 1'b0;
  endtask

  task automatic wake_cpu();
    @(posedge clk_sys);
    wake <= 1'b1;
    ls_on <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
  endtask
endmodule

// File: testbench/pmc_power_mode_controller_tb_top.sv
// Self-checking testbench for the power mode controller
`timescale 1ns/1ps
module pmc_power_mode_controller_tb_top;
  import pmc_pkg::*;
  localparam int AUTO = 8;
  localparam int RECOV = 20;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0] fast_on;
  logic ls_on, ls_stop, fast_stop, sleep_enter, wake, ls_clk, pp;
  pmc_state_t regulator_state;
  logic regulator_economy, charge_pump_en, pump_clk, irq;
  int err_count = 0;
  int tests_run = 0;
  int n;

  always #12.5 clk_sys = ~clk_sys;

  pmc_clk_cpu_model i_cpu (.fast_on(fast_on), .ls_on(ls_on), .ls_stop(ls_stop), .fast_stop(fast_stop),
    .sleep_enter(sleep_enter), .wake(wake), .ls_clk(ls_clk), .clk_sys(clk_sys));

  pmc_power_mode_controller #(.AUTO_CYC(AUTO), .RECOVER_CYC(RECOV)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .internal_fast_osc_on(fast_on[0]),
    .external_fast_osc_on(fast_on[1]), .external_clock_input_on(fast_on[2]), .lowspeed_crystal_osc_on(ls_on),
    .lowspeed_osc_sleep_stop(ls_stop), .fast_osc_sleep_stop(fast_stop), .cpu_sleep_enter(sleep_enter),
    .cpu_wake(wake), .lowspeed_osc_clk(ls_clk), .regulator_state(regulator_state),
    .regulator_economy(regulator_economy), .charge_pump_en(charge_pump_en), .pump_clk(pump_clk), .irq(irq));

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask

  task automatic st_chk(input int cyc, input pmc_state_t exp);
    repeat (cyc) @(posedge clk_sys);
    #1;
    chk("regulator_state", {12'h000, exp}, {12'h000, regulator_state});
    chk("regulator_economy", {15'h0000, exp == PMC_ST_ECONOMY}, {15'h0000, regulator_economy});
    chk("charge_pump_en", {15'h0000, exp == PMC_ST_SUPER}, {15'h0000, charge_pump_en});
    if (exp != PMC_ST_SUPER) begin
      chk("pump_clk", 16'h0000, {15'h0000, pump_clk});
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(i * 4), (i == 5) ? 16'h0001 : 16'h0000);
    end
    // Protected mode field
    wr_reg(8'h04, 16'h0003);
    rd_chk(8'h04, 16'h0000);
    st_chk(3, PMC_ST_NORMAL);
    wr_reg(8'h00, 16'h0096);
    rd_chk(8'h00, 16'h0001);
    wr_reg(8'h04, 16'h0002);
    rd_chk(8'h04, 16'h0002);
    i_cpu.set_fast(3'h0);
    st_chk(AUTO + 4, PMC_ST_NORMAL);
    wr_reg(8'h04, 16'h0003);
    st_chk(3, PMC_ST_ECONOMY);
    wr_reg(8'h04, 16'h0002);
    st_chk(3, PMC_ST_NORMAL);
    wr_reg(8'h04, 16'h0004);
    rd_chk(8'h04, 16'h0002);
    // Automatic economy after timed wait, sticky flag and interrupt
    wr_reg(8'h04, 16'h0000);
    st_chk(4, PMC_ST_NORMAL);
    st_chk(AUTO + 1, PMC_ST_ECONOMY);
    rd_chk(8'h0C, 16'h0001);
    wr_reg(8'h10, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", 16'h0001, {15'h0000, irq});
    rd_chk(8'h0C, 16'h0001);
    wr_reg(8'h0C, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", 16'h0000, {15'h0000, irq});
    rd_chk(8'h0C, 16'h0000);
    // Fast source start and sleep with a fast source active
    i_cpu.set_fast(3'h2);
    st_chk(3, PMC_ST_NORMAL);
    i_cpu.sleep_cpu();
    st_chk(3, PMC_ST_NORMAL);
    i_cpu.wake_cpu();
    st_chk(3, PMC_ST_NORMAL);
    // Sleep with every clock stopping
    i_cpu.set_fast(3'h0);
    i_cpu.sleep_cpu();
    st_chk(3, PMC_ST_ECONOMY);
    rd_chk(8'h0C, 16'h0000);
    i_cpu.wake_cpu();
    st_chk(3, PMC_ST_ECONOMY);
    i_cpu.set_fast(3'h4);
    st_chk(3, PMC_ST_NORMAL);
    // Sleep with fast sources configured to keep running: no immediate economy
    i_cpu.cfg_sleep(1'b1, 1'b0);
    i_cpu.set_fast(3'h0);
    i_cpu.sleep_cpu();
    st_chk(3, PMC_ST_NORMAL);
    i_cpu.set_fast(3'h4);
    i_cpu.wake_cpu();
    st_chk(3, PMC_ST_NORMAL);
    // Sleep with only the low-speed oscillator running
    i_cpu.cfg_sleep(1'b0, 1'b1);
    i_cpu.set_fast(3'h0);
    i_cpu.sleep_cpu();
    st_chk(4, PMC_ST_NORMAL);
    st_chk(AUTO + 1, PMC_ST_ECONOMY);
    rd_chk(8'h0C, 16'h0001);
    wr_reg(8'h0C, 16'h0001);
    i_cpu.wake_cpu();
    st_chk(3, PMC_ST_ECONOMY);
    // Super economy with charge pump clock ratio 4
    wr_reg(8'h08, 16'h0001);
    rd_chk(8'h08, 16'h0001);
    wr_reg(8'h04, 16'h0005);
    st_chk(3, PMC_ST_SUPER);
    n = 0;
    pp = pump_clk;
    repeat (544) begin
      @(posedge clk_sys);
      #1;
      if (pump_clk && !pp) begin
        n++;
      end
      pp = pump_clk;
    end
    chk("pump_rises", 16'h0001, {15'h0000, n inside {[9:11]}});
    // Leaving super economy through automatic mode
    wr_reg(8'h04, 16'h0000);
    st_chk(3, PMC_ST_RECOVER);
    rd_chk(8'h0C, 16'h0000);
    repeat (RECOV) @(posedge clk_sys);
    rd_chk(8'h0C, 16'h0001);
    i_cpu.set_fast(3'h1);
    st_chk(3, PMC_ST_NORMAL);
    // Protection restored
    wr_reg(8'h00, 16'h1234);
    rd_chk(8'h00, 16'h0000);
    wr_reg(8'h04, 16'h0002);
    rd_chk(8'h04, 16'h0000);
    give_verdict();
  end
endmodule
